/* File: rtl/cbt_defs.svh */
/*
 * Offsets, field positions, reset values and timing counts for the CAN
 * bit-timing and power-mode block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CBT_DEFS_SVH
`define CBT_DEFS_SVH

// Register word offsets (byte addresses)
`define CBT_OFF_CTRL      8'h00
`define CBT_OFF_BTR0      8'h04
`define CBT_OFF_BTR1      8'h08
`define CBT_OFF_STAT      8'h0C
`define CBT_OFF_TSTAMP    8'h10
`define CBT_OFF_TXDATA    8'h14

// Control register fields
`define CBT_CTRL_ENABLE   0
`define CBT_CTRL_CLOCK_SOURCE_SELECT   1
`define CBT_CTRL_LISTEN   2
`define CBT_CTRL_SLEEP_REQUEST    3
`define CBT_CTRL_STOPWAI  4
`define CBT_CTRL_WUPDET   5
`define CBT_CTRL_WUPIEN   6
`define CBT_CTRL_TSTAMP   7
`define CBT_CTRL_INITRQ   8
`define CBT_CTRL_SAMP3    9
`define CBT_CTRL_RESET    32'h0000_0100

// Bit timing register zero: prescaler [5:0], jump width [7:6]
`define CBT_BTR0_RESET    32'h0000_0000
// Bit timing register one: seg one [3:0], seg two [6:4]
`define CBT_BTR1_RESET    32'h0000_0023

// Status register fields
`define CBT_ST_SLEEP_ACKNOWLEDGE      0
`define CBT_ST_PDOWN      1
`define CBT_ST_WUPIRQ     2
`define CBT_ST_RXBIT      3
`define CBT_ST_TXACT      4

// Timer width
`define CBT_TIMER_W       16

`endif

/* File: rtl/cbt_pkg.sv */
/*
 * Types for the CAN bit-timing and power-mode block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cbt_pkg;
    typedef enum logic [1:0] {
        CBT_SEG_SYNC = 2'h0,
        CBT_SEG_ONE  = 2'h1,
        CBT_SEG_TWO  = 2'h3
    } cbt_seg_t;

    typedef enum logic [1:0] {
        CBT_MODE_NORMAL = 2'h0,
        CBT_MODE_SLEEP  = 2'h1,
        CBT_MODE_PDOWN  = 2'h3,
        CBT_MODE_OFF    = 2'h2
    } cbt_mode_t;
endpackage

/* File: rtl/cbt_stamp_mem.sv */
/*
 * Small time stamp store: one slot for the receive buffer, one for the
 * transmit buffer; read data come from a register.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "cbt_defs.svh"

module cbt_stamp_mem (
    // Clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_i,
    // Write side
    input  wire logic                   wr_en_i,
    input  wire logic                   wr_sel_i,
    input  wire logic [`CBT_TIMER_W-1:0] wr_data_i,
    // Read side
    input  wire logic                   rd_sel_i,
    output logic      [`CBT_TIMER_W-1:0] rd_data_o
);
    logic [`CBT_TIMER_W-1:0] slot_q [2];

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            slot_q[0] <= 16'h0000;
            slot_q[1] <= 16'h0000;
        end else if (wr_en_i) begin
            slot_q[wr_sel_i] <= wr_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_data_o <= 16'h0000;
        end else begin
            rd_data_o <= slot_q[rd_sel_i];
        end
    end
endmodule

/* File: rtl/cbt_core.sv */
/*
 * CAN bit timing, listen-only steering, time stamps and power modes,
 * with an Avalon-MM register slave.
 * Assumes a protocol engine that supplies transmit bits and frame-end
 * strobes, a CPU that reports run/wait/stop, and a bus transceiver.
 */
// Function
// - A select bit picks oscillator clock or bus clock as protocol clock.
// - Quantum clock is the protocol clock divided by a programmable prescaler.
// - Bit is one sync quantum, then segment one, then segment two.
// - Segment one lasts 1 to 16 quanta via its field.
// - Segment two lasts 1 to 8 quanta via its field.
// - New transmit bit goes onto the bus at the start of the bit.
// - Bus is sampled between segments; three-sample mode takes the majority of three quanta.
// - Jump width is programmable from 1 to 4 quanta.
// - Segment and jump width fields hold length minus one.
// - With stamping on, timer value is stored at each valid frame end.
// - Listen-only receives, drives recessive only, and starts no transmission.
// - Listen-only loops dominant bits back internally to the receiver.
// - Cleared module enable stops the block clocks.
// - Sleep stops all clocks except register access.
// - Power-down stops every clock including register access.
// - Wake-up interrupt needs sleep, wake detection and interrupt enable.
// - With CPU running, only sleep is a reduced power state.
// - CPU wait with stop-in-wait set forces power-down.
// - Leaving wait power-down clears sleep acknowledge for one cycle; a held sleep request resumes sleep.
// - CPU wait without stop-in-wait keeps normal or sleep operation.
// - CPU stop forces power-down unless module enable is cleared.
// - Power-down or initialization forces the transmit output recessive.
`timescale 1ns/1ps
`include "cbt_defs.svh"

module cbt_core (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // Protocol clock sources, as one-cycle enables
    input  wire logic        osc_tick_i,
    input  wire logic        bus_tick_i,
    // CPU mode
    input  wire logic        cpu_wait_i,
    input  wire logic        cpu_stop_i,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Protocol engine side
    input  wire logic        tx_req_i,
    input  wire logic        tx_bit_i,
    input  wire logic        frame_ok_i,
    input  wire logic        frame_is_tx_i,
    output logic             tx_point_o,
    output logic             sample_point_o,
    output logic             rx_bit_o,
    output logic             tx_active_o,
    // Bus pins
    input  wire logic        bus_receive_i,
    output logic             bus_transmit_output,
    // Power and interrupt
    output logic             core_clk_en_o,
    output logic             reg_clk_en_o,
    output logic             wakeup_irq_o
);
    ////////////////////////////////////////////////////////////////////////
    // Registers and mode decode
    logic [31:0] ctrl_q;
    logic [31:0] btr0_q;
    logic [31:0] btr1_q;
    logic        sleep_acknowledge_q;
    logic        wup_q;
    logic [`CBT_TIMER_W-1:0] timer_q;
    logic        acc_q;
    cbt_pkg::cbt_mode_t mode;
    logic        pdown, pdown_q, sleeping, run_en;
    logic        init_rq, listen, ack_ok, hit_wr, hit_rd;

    assign init_rq  = ctrl_q[`CBT_CTRL_INITRQ];
    assign listen   = ctrl_q[`CBT_CTRL_LISTEN];
    assign sleeping = ctrl_q[`CBT_CTRL_SLEEP_REQUEST] && sleep_acknowledge_q;

    always_comb begin
        if (!ctrl_q[`CBT_CTRL_ENABLE]) begin
            mode = cbt_pkg::CBT_MODE_OFF;
        end else if (cpu_stop_i) begin
            mode = cbt_pkg::CBT_MODE_PDOWN;
        end else if (cpu_wait_i && ctrl_q[`CBT_CTRL_STOPWAI]) begin
            mode = cbt_pkg::CBT_MODE_PDOWN;
        end else if (sleeping) begin
            mode = cbt_pkg::CBT_MODE_SLEEP;
        end else begin
            mode = cbt_pkg::CBT_MODE_NORMAL;
        end
    end

    assign pdown         = (mode == cbt_pkg::CBT_MODE_PDOWN);
    assign core_clk_en_o = (mode == cbt_pkg::CBT_MODE_NORMAL);
    assign reg_clk_en_o  = (mode == cbt_pkg::CBT_MODE_NORMAL)
                        || (mode == cbt_pkg::CBT_MODE_SLEEP);
    assign run_en        = core_clk_en_o && !init_rq;

    // Register access is refused while power-down holds the clocks
    assign ack_ok          = acc_q && !pdown;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ok;
    assign hit_wr          = avs_write && ack_ok;
    assign hit_rd          = avs_read && ack_ok;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            acc_q <= 1'b0;
        end else begin
            acc_q <= (avs_read || avs_write) && !acc_q && !pdown;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl_q <= `CBT_CTRL_RESET;
            btr0_q <= `CBT_BTR0_RESET;
            btr1_q <= `CBT_BTR1_RESET;
        end else if (hit_wr) begin
            unique case (avs_address)
                `CBT_OFF_CTRL: ctrl_q <= {22'h0, avs_writedata[9:0]};
                `CBT_OFF_BTR0: begin
                    if (init_rq) begin
                        btr0_q <= {24'h0, avs_writedata[7:0]};
                    end
                end
                `CBT_OFF_BTR1: begin
                    if (init_rq) begin
                        btr1_q <= {25'h0, avs_writedata[6:0]};
                    end
                end
                default: ;
            endcase
        end
    end

    // Sleep acknowledge follows the request once no transmission is active
    always_ff @(posedge core_clk_i) begin
        if (rst_i || pdown_q && !pdown) begin
            sleep_acknowledge_q <= 1'b0;
        end else if (!ctrl_q[`CBT_CTRL_SLEEP_REQUEST]) begin
            sleep_acknowledge_q <= 1'b0;
        end else if (!tx_active_o) begin
            sleep_acknowledge_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pdown_q <= 1'b0;
        end else begin
            pdown_q <= pdown;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus input synchroniser: three flops, change taken when 2 and 3 agree
    logic [2:0] rx_sync_q;
    logic       rx_q, rx_prev_q, rx_in;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rx_sync_q <= 3'h7;
            rx_q      <= 1'b1;
        end else begin
            rx_sync_q <= {rx_sync_q[1:0], bus_receive_i};
            if (rx_sync_q[1] == rx_sync_q[2]) begin
                rx_q <= rx_sync_q[2];
            end
        end
    end

    // Listen-only loops our dominant bits back to the receiver
    assign rx_in = rx_q && !(listen && tx_req_i && !tx_bit_i);

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and bit timing
    logic       pclk_tick, tq_tick, edge_seen;
    logic [5:0] pre_cnt_q;
    cbt_pkg::cbt_seg_t seg_q;
    logic [4:0] seg_cnt_q, seg1_len, seg2_len, phase_err;
    logic [2:0] sjw_len;

    function automatic logic [4:0] field_len(input logic [3:0] f);
        field_len = {1'b0, f} + 5'h01;
    endfunction

    assign pclk_tick = ctrl_q[`CBT_CTRL_CLOCK_SOURCE_SELECT] ? bus_tick_i
                                                : osc_tick_i;
    assign seg1_len  = field_len(btr1_q[3:0]);
    assign seg2_len  = field_len({1'b0, btr1_q[6:4]});
    assign sjw_len   = 3'(field_len({2'h0, btr0_q[7:6]}));

    always_ff @(posedge core_clk_i) begin
        if (rst_i || !run_en) begin
            pre_cnt_q <= 6'h00;
        end else if (pclk_tick) begin
            pre_cnt_q <= (pre_cnt_q == btr0_q[5:0]) ? 6'h00
                                                    : pre_cnt_q + 6'h01;
        end
    end

    assign tq_tick = run_en && pclk_tick && (pre_cnt_q == btr0_q[5:0]);

    assign edge_seen = rx_prev_q && !rx_in;
    assign phase_err = (seg_cnt_q > {2'h0, sjw_len}) ? {2'h0, sjw_len}
                                                     : seg_cnt_q;

    always_ff @(posedge core_clk_i) begin
        if (rst_i || !run_en) begin
            seg_q     <= cbt_pkg::CBT_SEG_SYNC;
            seg_cnt_q <= 5'h00;
            rx_prev_q <= 1'b1;
        end else if (tq_tick) begin
            rx_prev_q <= rx_in;
            unique case (seg_q)
                cbt_pkg::CBT_SEG_SYNC: begin
                    seg_q     <= cbt_pkg::CBT_SEG_ONE;
                    seg_cnt_q <= 5'h00;
                end
                cbt_pkg::CBT_SEG_ONE: begin
                    if (edge_seen && seg_cnt_q != 5'h00) begin
                        seg_cnt_q <= seg_cnt_q - phase_err;
                    end else if (seg_cnt_q + 5'h01 >= seg1_len) begin
                        seg_q     <= cbt_pkg::CBT_SEG_TWO;
                        seg_cnt_q <= 5'h00;
                    end else begin
                        seg_cnt_q <= seg_cnt_q + 5'h01;
                    end
                end
                cbt_pkg::CBT_SEG_TWO: begin
                    if (edge_seen && seg2_len - seg_cnt_q
                            <= {2'h0, sjw_len}) begin
                        seg_q     <= cbt_pkg::CBT_SEG_ONE;
                        seg_cnt_q <= 5'h00;
                    end else if (seg_cnt_q + 5'h01 >= seg2_len) begin
                        seg_q     <= cbt_pkg::CBT_SEG_SYNC;
                        seg_cnt_q <= 5'h00;
                    end else begin
                        seg_cnt_q <= seg_cnt_q + 5'h01;
                    end
                end
                default: begin
                    seg_q     <= cbt_pkg::CBT_SEG_SYNC;
                    seg_cnt_q <= 5'h00;
                end
            endcase
        end
    end

    assign tx_point_o = tq_tick && seg_q == cbt_pkg::CBT_SEG_SYNC;
    assign sample_point_o = tq_tick && seg_q == cbt_pkg::CBT_SEG_ONE
                         && seg_cnt_q + 5'h01 >= seg1_len
                         && !edge_seen;

    ////////////////////////////////////////////////////////////////////////
    // Sampling: single sample or majority of three quanta
    logic [2:0] samp_q;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            samp_q <= 3'h7;
        end else if (tq_tick) begin
            samp_q <= {samp_q[1:0], rx_in};
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rx_bit_o <= 1'b1;
        end else if (sample_point_o) begin
            if (ctrl_q[`CBT_CTRL_SAMP3]) begin
                rx_bit_o <= (samp_q[1] & samp_q[0]) | (samp_q[1] & rx_in)
                          | (samp_q[0] & rx_in);
            end else begin
                rx_bit_o <= rx_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit drive
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !run_en) begin
            tx_active_o <= 1'b0;
        end else if (tx_point_o) begin
            tx_active_o <= tx_req_i && !listen;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || pdown || init_rq) begin
            bus_transmit_output <= 1'b1;
        end else if (tx_point_o) begin
            bus_transmit_output <= listen || !tx_req_i || tx_bit_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer and time stamps; the stamp store holds rx and tx slots
    logic        stamp_wr;
    logic [15:0] stamp_rd;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            timer_q <= 16'h0000;
        end else if (tx_point_o) begin
            timer_q <= timer_q + 16'h0001;
        end
    end

    assign stamp_wr = frame_ok_i && ctrl_q[`CBT_CTRL_TSTAMP] && run_en;

    cbt_stamp_mem u_stamp (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .wr_en_i    (stamp_wr),
        .wr_sel_i   (frame_is_tx_i),
        .wr_data_i  (timer_q),
        .rd_sel_i   (avs_address == `CBT_OFF_TXDATA),
        .rd_data_o  (stamp_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Wake-up: sticky on a dominant bus level while sleeping; set beats clear
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wup_q <= 1'b0;
        end else if (sleeping && ctrl_q[`CBT_CTRL_WUPDET] && !rx_q) begin
            wup_q <= 1'b1;
        end else if (hit_wr && avs_address == `CBT_OFF_STAT
                     && avs_writedata[`CBT_ST_WUPIRQ]) begin
            wup_q <= 1'b0;
        end
    end

    assign wakeup_irq_o = wup_q && sleeping && ctrl_q[`CBT_CTRL_WUPDET]
                       && ctrl_q[`CBT_CTRL_WUPIEN];

    ////////////////////////////////////////////////////////////////////////
    // Read data; the stamp arrives one cycle late, matching the answer
    always_comb begin
        avs_readdata = 32'h0000_0000;
        if (hit_rd) begin
            unique case (avs_address)
                `CBT_OFF_CTRL: avs_readdata = ctrl_q;
                `CBT_OFF_BTR0: avs_readdata = btr0_q;
                `CBT_OFF_BTR1: avs_readdata = btr1_q;
                `CBT_OFF_STAT: avs_readdata = {27'h0, tx_active_o, rx_bit_o,
                                    wup_q, pdown, sleep_acknowledge_q};
                `CBT_OFF_TSTAMP,
                `CBT_OFF_TXDATA: avs_readdata = {16'h0, stamp_rd};
                default: avs_readdata = 32'h0000_0000;
            endcase
        end
    end
endmodule

/* File: dv/cbt_core_props.sv */
/* Port checker for cbt_core: access latency, clock enables, bus levels.
   Assumes it is bound to cbt_core: one clock, synchronous reset. */
`timescale 1ns/1ps
module cbt_core_props (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic cpu_wait_i,
    input wire logic cpu_stop_i,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic tx_point_o,
    input wire logic sample_point_o,
    input wire logic rx_bit_o,
    input wire logic bus_transmit_output,
    input wire logic core_clk_en_o,
    input wire logic reg_clk_en_o,
    input wire logic wakeup_irq_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    sequence s_new_req;
        $rose(avs_read || avs_write) && !cpu_wait_i && !cpu_stop_i;
    endsequence
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence s_held_stop;
        cpu_stop_i && $past(cpu_stop_i);
    endsequence
    a_access_one_wait: assert property (s_new_req |-> s_one_wait)
        else $error("access not answered after one wait");
    a_stop_core_off: assert property (s_held_stop |-> !core_clk_en_o)
        else $error("core clock runs in stop");
    a_stop_reg_off: assert property (s_held_stop |-> !reg_clk_en_o)
        else $error("register clock runs in stop");
    a_stop_recessive: assert property (s_held_stop |-> bus_transmit_output)
        else $error("dominant output in stop");
    a_core_needs_reg: assert property (core_clk_en_o |-> reg_clk_en_o)
        else $error("core clock without register clock");
    a_tx_at_point: assert property ($fell(bus_transmit_output)
        |-> tx_point_o || $past(tx_point_o))
        else $error("dominant started off the transmit point");
    a_rx_at_sample: assert property ($changed(rx_bit_o)
        |-> sample_point_o || $past(sample_point_o))
        else $error("received bit changed off the sample point");
    a_wake_in_sleep: assert property ($rose(wakeup_irq_o)
        |-> $past(reg_clk_en_o && !core_clk_en_o))
        else $error("wake interrupt outside sleep");
endmodule
bind cbt_core cbt_core_props u_props (.core_clk_i, .rst_i, .cpu_wait_i,
    .cpu_stop_i, .avs_read, .avs_write, .avs_waitrequest, .tx_point_o,
    .sample_point_o, .rx_bit_o, .bus_transmit_output, .core_clk_en_o,
    .reg_clk_en_o, .wakeup_irq_o);

/* File: dv/cbt_node_model.sv */
/* Another bus node behind a transceiver: wired-AND bus with pull-up.
   Assumes bit length in core cycles is set by the bench. */
`timescale 1ns/1ps
module cbt_node_model (
    // Clock
    input  wire logic        core_clk_i,
    // Bus and command
    input  wire logic        dut_tx_i,
    input  wire logic        send_i,
    input  wire logic [15:0] bit_len_i,
    output logic             bus_o
);
    logic        dom_q;
    logic [15:0] cnt_q;
    initial begin
        dom_q = 1'b0;
        cnt_q = 16'h0000;
    end
    // Toggles dominant and recessive bits while sending
    always @(posedge core_clk_i) begin
        if (!send_i) begin
            cnt_q <= 16'h0000;
            dom_q <= 1'b0;
        end else if (cnt_q + 16'h0001 >= bit_len_i) begin
            cnt_q <= 16'h0000;
            dom_q <= !dom_q;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    // Pull-up: recessive unless some node drives dominant
    assign bus_o = dut_tx_i && !dom_q;
endmodule

/* File: dv/tb_can_bit_timing_power_modes.sv */
/* Bench for cbt_core: registers, bit timing, power modes, listen-only,
   time stamps. Assumes cbt_defs.svh on the include path. */
`timescale 1ns/1ps
`include "cbt_defs.svh"
module tb_can_bit_timing_power_modes;
    logic        core_clk_i, rst_i, osc_tick_i, bus_tick_i, cpu_wait_i;
    logic        cpu_stop_i, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic        tx_req_i, tx_bit_i, frame_ok_i, frame_is_tx_i, tx_point_o;
    logic        sample_point_o, rx_bit_o, tx_active_o, bus_receive_i;
    logic        bus_transmit_output, core_clk_en_o, reg_clk_en_o;
    logic        wakeup_irq_o, node_send, m, q;
    logic [15:0] node_len;
    int          fail_count, samples_checked, cyc, tc, n, p;
    int          src[4] = '{1, 1, 0, 0};
    int          psc[4] = '{1, 2, 1, 4};
    int          s1[4]  = '{4, 16, 4, 16};
    int          s2[4]  = '{2, 8, 8, 2};
    int          jw[4]  = '{1, 4, 2, 1};
    cbt_core u_dut (.core_clk_i, .rst_i, .osc_tick_i, .bus_tick_i,
        .cpu_wait_i, .cpu_stop_i, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .tx_req_i,
        .tx_bit_i, .frame_ok_i, .frame_is_tx_i, .tx_point_o,
        .sample_point_o, .rx_bit_o, .tx_active_o, .bus_receive_i,
        .bus_transmit_output, .core_clk_en_o, .reg_clk_en_o, .wakeup_irq_o);
    cbt_node_model u_node (.core_clk_i, .dut_tx_i(bus_transmit_output),
        .send_i(node_send), .bit_len_i(node_len), .bus_o(bus_receive_i));
    ////////////////////////////////////////////////////////////
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = !core_clk_i;
    end
    // Oscillator ticks every 3 cycles, bus ticks every 2
    always @(posedge core_clk_i) begin
        tc <= tc + 1;
        osc_tick_i <= (tc % 3 == 0);
        bus_tick_i <= (tc % 2 == 0);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e, input string s);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    // Holds the request until waitrequest is seen low at an edge
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk_i);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge core_clk_i);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        acc(1'b1, a, v, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, string s);
        acc(1'b0, a, 32'h0000_0000, d);
        chk(d, e, s);
    endtask
    task automatic wt(input int k);
        repeat (k) @(negedge core_clk_i);
    endtask
    task automatic pulse(input logic t);
        @(posedge core_clk_i);
        frame_ok_i <= 1'b1;
        frame_is_tx_i <= t;
        @(posedge core_clk_i);
        frame_ok_i <= 1'b0;
        wt(3);
    endtask
    // Cycles between two rises of the transmit point
    task automatic meas(output int r);
        int k, r0;
        logic pv;
        k = 0;
        r0 = -1;
        r = 0;
        pv = 1'b1;
        while (r == 0 && k < 3000) begin
            @(negedge core_clk_i);
            k++;
            if (tx_point_o === 1'b1 && pv !== 1'b1) begin
                if (r0 < 0) r0 = k;
                else r = k - r0;
            end
            pv = tx_point_o;
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {rst_i, osc_tick_i, bus_tick_i, cpu_wait_i, cpu_stop_i} = 5'h10;
        {avs_read, avs_write, tx_req_i, tx_bit_i} = 4'h1;
        {frame_ok_i, frame_is_tx_i, node_send} = 3'h0;
        {avs_address, avs_writedata, node_len} = 56'h0;
        {fail_count, samples_checked, cyc, tc} = 128'h0;
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        wt(1);
        chk({core_clk_en_o, bus_transmit_output}, 2'h1, "reset pins");
        rd(`CBT_OFF_CTRL, `CBT_CTRL_RESET, "ctrl reset");
        rd(`CBT_OFF_BTR1, `CBT_BTR1_RESET, "btr1 reset");
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000, "unmapped");
        $display("test reset done");
        // Boundary lengths on purpose: compliance is left to software
        for (int i = 0; i < 4; i++) begin
            wr(`CBT_OFF_CTRL, 32'h0000_0100);
            wr(`CBT_OFF_BTR0, 32'((jw[i] - 1) << 6 | (psc[i] - 1)));
            rd(`CBT_OFF_BTR0, 32'((jw[i] - 1) << 6 | (psc[i] - 1)), "b0");
            wr(`CBT_OFF_BTR1, 32'((s2[i] - 1) << 4 | (s1[i] - 1)));
            rd(`CBT_OFF_BTR1, 32'((s2[i] - 1) << 4 | (s1[i] - 1)), "b1");
            wr(`CBT_OFF_CTRL, 32'(1 | src[i] << 1));
            meas(p);
            n = (src[i] ? 2 : 3) * psc[i] * (1 + s1[i] + s2[i]);
            chk(32'(p), 32'(n), "bit period");
        end
        $display("test bit timing done");
        node_len <= 16'h000A;
        for (int ie = 0; ie < 2; ie++) begin
            wr(`CBT_OFF_CTRL, 32'(8'h29 | ie << 6));
            wt(10);
            chk({reg_clk_en_o, core_clk_en_o}, 2'h2, "sleep");
            @(posedge core_clk_i);
            node_send <= 1'b1;
            n = 0;
            while (wakeup_irq_o !== 1'b1 && n < 100) begin
                wt(1);
                n++;
            end
            chk(wakeup_irq_o, 32'(ie), "wake irq");
            @(posedge core_clk_i);
            node_send <= 1'b0;
            wt(8);
            wr(`CBT_OFF_STAT, 32'h0000_0004);
            rd(`CBT_OFF_STAT, 32'h0000_0009, "wake clear");
            wr(`CBT_OFF_CTRL, 32'h0000_0001);
            wt(5);
            chk(core_clk_en_o, 32'h1, "normal");
        end
        for (int s = 0; s < 2; s++) begin
            wr(`CBT_OFF_CTRL, 32'(1 | s << 4));
            @(posedge core_clk_i);
            cpu_wait_i <= 1'b1;
            wt(5);
            chk({reg_clk_en_o, core_clk_en_o}, s ? 0 : 3, "wait");
            @(posedge core_clk_i);
            cpu_wait_i <= 1'b0;
            wt(5);
            chk(core_clk_en_o, 32'h1, "after wait");
        end
        @(posedge core_clk_i);
        cpu_stop_i <= 1'b1;
        wt(5);
        chk({bus_transmit_output, reg_clk_en_o, core_clk_en_o}, 4, "stop");
        fork
            rd(`CBT_OFF_CTRL, 32'h0000_0011, "held read");
            begin
                wt(12);
                chk(avs_waitrequest, 32'h1, "no answer");
                @(posedge core_clk_i);
                cpu_stop_i <= 1'b0;
            end
        join
        $display("test power modes done");
        for (int t = 0; t < 2; t++) begin
            wr(`CBT_OFF_CTRL, 32'(1 | t << 7));
            pulse(1'b0);
            acc(1'b0, `CBT_OFF_TSTAMP, 32'h0, d);
            chk(d != 0, 32'(t), "rx stamp");
        end
        acc(1'b0, `CBT_OFF_TXDATA, 32'h0, d);
        chk(d, 32'h0, "tx stamp idle");
        pulse(1'b1);
        acc(1'b0, `CBT_OFF_TXDATA, 32'h0, d);
        chk(d != 0, 32'h1, "tx stamp");
        $display("test time stamp done");
        for (int lo = 1; lo >= 0; lo--) begin
            wr(`CBT_OFF_CTRL, 32'(32'h201 | lo << 2));
            @(posedge core_clk_i);
            tx_bit_i <= 1'b0;
            tx_req_i <= 1'b1;
            {m, q} = 2'h2;
            repeat (700) begin
                wt(1);
                m = m & bus_transmit_output;
                q = q | tx_active_o;
            end
            chk({q, m}, lo ? 1 : 2, "tx drive");
            chk(rx_bit_o, 32'h0, "rx dominant");
            wr(`CBT_OFF_CTRL, 32'h0000_0101);
            wt(3);
            chk(bus_transmit_output, 32'h1, "init recessive");
            @(posedge core_clk_i);
            tx_req_i <= 1'b0;
            tx_bit_i <= 1'b1;
        end
        $display("test transmit done");
        print_verdict();
    end
endmodule
